// ---- core/rad_pkg.sv ----
// Package for the automatic transmit-direction control block
package rad_pkg;

  // Port count and bus geometry
  localparam int NUM_PORTS = 6;
  localparam int ADR_W = 8;
  localparam int OPT_REGS = 4;

  // Register byte offsets
  localparam logic [ADR_W-1:0] OFS_OPT12 = 8'h00;
  localparam logic [ADR_W-1:0] OFS_OPT34 = 8'h04;
  localparam logic [ADR_W-1:0] OFS_OPT5 = 8'h08;
  localparam logic [ADR_W-1:0] OFS_OPT6 = 8'h0c;
  localparam logic [ADR_W-1:0] OFS_STATUS = 8'h10;
  localparam logic [ADR_W-1:0] OFS_PINS = 8'h14;

  // Option register indices
  localparam logic [1:0] IDX_OPT12 = 2'h0;
  localparam logic [1:0] IDX_OPT34 = 2'h1;
  localparam logic [1:0] IDX_OPT5 = 2'h2;
  localparam logic [1:0] IDX_OPT6 = 2'h3;

  // Field positions inside one port nibble
  localparam int EN_BIT = 0;
  localparam int SEL_BIT = 1;
  localparam int POL_BIT = 2;
  localparam int HI_NIB = 4;

  // Writable bits: two ports share a byte, or one port alone
  localparam logic [7:0] MASK_PAIR = 8'h77;
  localparam logic [7:0] MASK_SINGLE = 8'h07;
  localparam logic [7:0] OPT_RST = 8'h00;

  // Select encoding
  localparam logic SEL_RTS = 1'b1;

  // Status and pin register field positions
  localparam int ST_EMPTY_LSB = 0;
  localparam int ST_ACTIVE_LSB = 8;
  localparam int ST_HISPD_LSB = 16;
  localparam int PIN_RTS_LSB = 0;
  localparam int PIN_DTR_LSB = 8;

  // Bus handshake states
  typedef enum logic [1:0] {
    BUS_IDLE = 2'b01,
    BUS_ACK = 2'b10
  } rad_bus_e;

  // Per-port option fields
  typedef struct packed {
    logic pol;
    logic sel;
    logic en;
  } rad_cfg_s;

  // Per-port signals from the owning UART
  typedef struct packed {
    logic mcrRtsN;
    logic mcrDtrN;
    logic txFifoEmpty;
    logic txShiftEmpty;
    logic fifoEnabled;
    logic divisorMsb;
  } rad_uart_s;

  // Per-port modem outputs
  typedef struct packed {
    logic rtsN;
    logic dtrN;
  } rad_pins_s;

endpackage

// ---- core/rad_port_ctl.sv ----
// Direction override for one serial port
`timescale 1ns/10ps
module rad_port_ctl
  import rad_pkg::*;
(
  input wire rad_cfg_s cfg,
  input wire rad_uart_s uart,
  output wire rad_pins_s pins,
  output wire active,
  output wire bufEmpty
);

  wire level;
  wire ctlRts;
  wire ctlDtr;

  // Empty only once the last stop bit has left the shifter
  assign bufEmpty = uart.txFifoEmpty & uart.txShiftEmpty;

  // Feature is meaningless with the FIFO off, so it is gated here
  assign active = cfg.en & uart.fifoEnabled;

  // Polarity level when empty, its inverse while data remains
  assign level = bufEmpty ? cfg.pol : ~cfg.pol;

  // Only the selected output is taken over
  assign ctlRts = active & (cfg.sel == SEL_RTS);
  assign ctlDtr = active & (cfg.sel != SEL_RTS);

  // Unselected output keeps its modem-control level
  assign pins.rtsN = ctlRts ? level : uart.mcrRtsN;
  assign pins.dtrN = ctlDtr ? level : uart.mcrDtrN;

endmodule

// ---- core/rad_top.sv ----
// Automatic transmit-direction control for six UART ports
//
// The register offsets and the Wishbone interface to the registers were left to the implementer.
`timescale 1ns/10ps
module rad_top
  import rad_pkg::*;
#(
  parameter int PORTS = NUM_PORTS
) (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic wbCycI,
  input wire logic wbStbI,
  input wire logic wbWeI,
  input wire logic [ADR_W-1:0] wbAdrI,
  input wire logic [31:0] wbDatI,
  input wire logic [3:0] wbSelI,
  output logic [31:0] wbDatO,
  output logic wbAckO,
  input wire rad_uart_s [PORTS-1:0] uartIn,
  input wire logic [PORTS-1:0] gpioDirOe,
  output logic [PORTS-1:0] requestToSendOutN,
  output logic [PORTS-1:0] terminalReadyOutN,
  output logic [PORTS-1:0] highSpeedBaudSel,
  output logic [PORTS-1:0] serialPinOe
);

  // Merge one written byte into an option register
  function automatic logic [7:0] mergeByte(
    input logic [7:0] old,
    input logic [31:0] data,
    input logic laneEn,
    input logic [7:0] mask
  );
    logic [7:0] res;
    res = old;
    if (laneEn) begin
      res = data[7:0] & mask;
    end
    return res;
  endfunction

  // Pull one port's fields out of an option byte
  function automatic rad_cfg_s pickCfg(
    input logic [7:0] opt,
    input logic hiNib
  );
    rad_cfg_s c;
    logic [2:0] nib;
    nib = hiNib ? opt[HI_NIB +: 3] : opt[2:0];
    c.en = nib[EN_BIT];
    c.sel = nib[SEL_BIT];
    c.pol = nib[POL_BIT];
    return c;
  endfunction

  // Widen one option byte onto the read bus
  function automatic logic [31:0] widenByte(
    input logic [7:0] b
  );
    logic [31:0] w;
    w = 32'h0000_0000;
    w[7:0] = b;
    return w;
  endfunction

  // One bit per port in a byte; spare slots read zero
  function automatic logic [7:0] padPorts(
    input logic [PORTS-1:0] v
  );
    logic [7:0] r;
    r = 8'h00;
    r[PORTS-1:0] = v;
    return r;
  endfunction

  // Option storage, one byte each
  logic [7:0] optQ [OPT_REGS];
  logic [7:0] optD [OPT_REGS];

  // Bus slave state
  rad_bus_e busQ;
  rad_bus_e busD;
  logic ackQ;
  logic [31:0] rdatQ;
  logic [31:0] rdatD;

  // Registered pin outputs
  logic [PORTS-1:0] rtsQ;
  logic [PORTS-1:0] dtrQ;
  logic [PORTS-1:0] hiSpdQ;
  logic [PORTS-1:0] oeQ;

  // Per-port results from the port controllers
  rad_cfg_s [PORTS-1:0] portCfg;
  rad_pins_s [PORTS-1:0] portPins;
  logic [PORTS-1:0] portActive;
  logic [PORTS-1:0] portEmpty;
  logic [PORTS-1:0] rtsNext;
  logic [PORTS-1:0] dtrNext;

  // Bus decode
  wire busReq;
  wire accept;
  wire wrStrobe;
  wire rdStrobe;
  wire ackD;
  wire wrOpt12;
  wire wrOpt34;
  wire wrOpt5;
  wire wrOpt6;
  wire hitOpt12;
  wire hitOpt34;
  wire hitOpt5;
  wire hitOpt6;
  wire hitStatus;
  wire hitPins;
  wire [31:0] statusWord;
  wire [31:0] pinsWord;
  wire [7:0] emptyBits;
  wire [7:0] activeBits;
  wire [7:0] hiSpdBits;
  wire [7:0] rtsBits;
  wire [7:0] dtrBits;
  logic [31:0] readMux;

  // A request is taken once per handshake, ack drops next cycle
  assign busReq = wbCycI & wbStbI;
  assign accept = busReq & (busQ == BUS_IDLE);
  assign wrStrobe = accept & wbWeI;
  assign rdStrobe = accept & ~wbWeI;

  // Address decode on aligned word offsets
  assign hitOpt12 = (wbAdrI == OFS_OPT12);
  assign hitOpt34 = (wbAdrI == OFS_OPT34);
  assign hitOpt5 = (wbAdrI == OFS_OPT5);
  assign hitOpt6 = (wbAdrI == OFS_OPT6);
  assign hitStatus = (wbAdrI == OFS_STATUS);
  assign hitPins = (wbAdrI == OFS_PINS);

  // Per-register write strobes; other offsets ignore writes
  assign wrOpt12 = wrStrobe & hitOpt12;
  assign wrOpt34 = wrStrobe & hitOpt34;
  assign wrOpt5 = wrStrobe & hitOpt5;
  assign wrOpt6 = wrStrobe & hitOpt6;

  // Ack gets its own flop so the output is a plain register
  assign ackD = (busD == BUS_ACK);

  // Handshake state: one idle cycle between acks
  always_comb begin
    busD = busQ;
    case (busQ)
      BUS_IDLE: begin
        if (busReq) begin
          busD = BUS_ACK;
        end
      end
      BUS_ACK: begin
        busD = BUS_IDLE;
      end
      default: begin
        busD = BUS_IDLE;
      end
    endcase
  end

  // Option register writes; byte lane 0 only carries data
  always_comb begin
    for (int r = 0; r < OPT_REGS; r++) begin
      optD[r] = optQ[r];
    end
    if (wrOpt12) begin
      optD[IDX_OPT12] = mergeByte(optQ[IDX_OPT12], wbDatI, wbSelI[0], MASK_PAIR);
    end
    if (wrOpt34) begin
      optD[IDX_OPT34] = mergeByte(optQ[IDX_OPT34], wbDatI, wbSelI[0], MASK_PAIR);
    end
    if (wrOpt5) begin
      optD[IDX_OPT5] = mergeByte(optQ[IDX_OPT5], wbDatI, wbSelI[0], MASK_SINGLE);
    end
    if (wrOpt6) begin
      optD[IDX_OPT6] = mergeByte(optQ[IDX_OPT6], wbDatI, wbSelI[0], MASK_SINGLE);
    end
  end

  // Port-to-register mapping: 1-2 share, 3-4 share, 5 and 6 alone
  assign portCfg[0] = pickCfg(optQ[IDX_OPT12], 1'b0);
  assign portCfg[1] = pickCfg(optQ[IDX_OPT12], 1'b1);
  assign portCfg[2] = pickCfg(optQ[IDX_OPT34], 1'b0);
  assign portCfg[3] = pickCfg(optQ[IDX_OPT34], 1'b1);
  assign portCfg[4] = pickCfg(optQ[IDX_OPT5], 1'b0);
  assign portCfg[5] = pickCfg(optQ[IDX_OPT6], 1'b0);

  // One direction controller per port
  genvar p;
  generate
    for (p = 0; p < PORTS; p++) begin : gPort
      rad_port_ctl uCtl (
        .cfg(portCfg[p]),
        .uart(uartIn[p]),
        .pins(portPins[p]),
        .active(portActive[p]),
        .bufEmpty(portEmpty[p])
      );
      assign rtsNext[p] = portPins[p].rtsN;
      assign dtrNext[p] = portPins[p].dtrN;
    end
  endgenerate

  // One byte per field; unused port slots read zero
  assign emptyBits = padPorts(portEmpty);
  assign activeBits = padPorts(portActive);
  assign hiSpdBits = padPorts(hiSpdQ);
  assign rtsBits = padPorts(rtsQ);
  assign dtrBits = padPorts(dtrQ);

  // Live state words for software
  assign statusWord = {
    8'h00, hiSpdBits,
    activeBits, emptyBits
  };
  assign pinsWord = {
    16'h0000,
    dtrBits, rtsBits
  };

  // Read selection; unmapped offsets read zero and still ack
  always_comb begin
    readMux = 32'h0000_0000;
    if (hitOpt12) begin
      readMux = widenByte(optQ[IDX_OPT12]);
    end else if (hitOpt34) begin
      readMux = widenByte(optQ[IDX_OPT34]);
    end else if (hitOpt5) begin
      readMux = widenByte(optQ[IDX_OPT5]);
    end else if (hitOpt6) begin
      readMux = widenByte(optQ[IDX_OPT6]);
    end else if (hitStatus) begin
      readMux = statusWord;
    end else if (hitPins) begin
      readMux = pinsWord;
    end
  end

  // Read data is latched with the ack and held otherwise
  assign rdatD = rdStrobe ? readMux : rdatQ;

  // Bus slave registers
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      busQ <= BUS_IDLE;
      ackQ <= 1'b0;
      rdatQ <= 32'h0000_0000;
    end else begin
      busQ <= busD;
      ackQ <= ackD;
      rdatQ <= rdatD;
    end
  end

  // Option registers start with every feature off
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      for (int r = 0; r < OPT_REGS; r++) begin
        optQ[r] <= OPT_RST;
      end
    end else begin
      for (int r = 0; r < OPT_REGS; r++) begin
        optQ[r] <= optD[r];
      end
    end
  end

  // Pin outputs; reset leaves both modem lines inactive high
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      rtsQ <= {PORTS{1'b1}};
      dtrQ <= {PORTS{1'b1}};
    end else begin
      rtsQ <= rtsNext;
      dtrQ <= dtrNext;
    end
  end

  // Divisor MSB picks the fast clock; no other path enables it
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      hiSpdQ <= {PORTS{1'b0}};
    end else begin
      for (int i = 0; i < PORTS; i++) begin
        hiSpdQ[i] <= uartIn[i].divisorMsb;
      end
    end
  end

  // Pin drive follows the pin controller, never the serial enable
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      oeQ <= {PORTS{1'b0}};
    end else begin
      oeQ <= gpioDirOe;
    end
  end

  // Outputs straight from flip-flops
  assign wbAckO = ackQ;
  assign wbDatO = rdatQ;
  assign requestToSendOutN = rtsQ;
  assign terminalReadyOutN = dtrQ;
  assign highSpeedBaudSel = hiSpdQ;
  assign serialPinOe = oeQ;

endmodule

// ---- bench/rad_line_xcvr.sv ----
// Half-duplex line transceiver model on port one
`timescale 1ns/10ps
module rad_line_xcvr (
  input wire logic driveEn,
  input wire logic txd,
  output logic busLine
);
  // Released bus sits at bias level, never the last bit
  assign busLine = driveEn ? txd : 1'b1;
endmodule

// ---- bench/rad_top_properties.sv ----
// Checker for the direction control ports
`timescale 1ns/10ps
module rad_top_checker
  import rad_pkg::*;
#(
  parameter int PORTS = NUM_PORTS
) (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic wbCycI,
  input wire logic wbStbI,
  input wire logic wbWeI,
  input wire logic [ADR_W-1:0] wbAdrI,
  input wire logic [31:0] wbDatI,
  input wire logic [3:0] wbSelI,
  input wire logic wbAckO,
  input wire rad_uart_s [PORTS-1:0] uartIn,
  input wire logic [PORTS-1:0] gpioDirOe,
  input wire logic [PORTS-1:0] requestToSendOutN,
  input wire logic [PORTS-1:0] terminalReadyOutN,
  input wire logic [PORTS-1:0] highSpeedBaudSel,
  input wire logic [PORTS-1:0] serialPinOe
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!resetn);
  logic armQ;
  rad_cfg_s shQ;
  logic [PORTS-1:0] msb;
  // Shadow of port one options; arm skips the reset-valued first edge
  wire take = wbCycI && wbStbI && !wbAckO;
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      armQ <= 1'b0;
      shQ <= '0;
    end else begin
      armQ <= 1'b1;
      if (take && wbWeI && wbSelI[0] && wbAdrI == OFS_OPT12) shQ <= wbDatI[2:0];
    end
  end
  // Expected port one levels
  wire act0 = shQ.en & uartIn[0].fifoEnabled;
  wire lvl0 = (uartIn[0].txFifoEmpty & uartIn[0].txShiftEmpty) ? shQ.pol : !shQ.pol;
  wire expR = (act0 && shQ.sel) ? lvl0 : uartIn[0].mcrRtsN;
  wire expD = (act0 && !shQ.sel) ? lvl0 : uartIn[0].mcrDtrN;
  always_comb for (int i = 0; i < PORTS; i++) msb[i] = uartIn[i].divisorMsb;
  a_rts_follow: assert property (armQ |-> requestToSendOutN[0] == $past(expR))
    else $error("rts level wrong");
  a_dtr_follow: assert property (armQ |-> terminalReadyOutN[0] == $past(expD))
    else $error("dtr level wrong");
  a_off_pass: assert property (armQ && $past(!shQ.en) |->
    requestToSendOutN[0] == $past(uartIn[0].mcrRtsN) &&
    terminalReadyOutN[0] == $past(uartIn[0].mcrDtrN))
    else $error("disabled port altered");
  a_fifo_off: assert property (armQ && $past(!uartIn[0].fifoEnabled) |->
    requestToSendOutN[0] == $past(uartIn[0].mcrRtsN))
    else $error("fifo off yet forced");
  a_shift_busy: assert property (armQ && $past(act0 && shQ.sel && !uartIn[0].txShiftEmpty)
    |-> requestToSendOutN[0] == $past(!shQ.pol))
    else $error("shift busy seen empty");
  a_one_side: assert property (armQ |-> requestToSendOutN[0] == $past(uartIn[0].mcrRtsN) ||
    terminalReadyOutN[0] == $past(uartIn[0].mcrDtrN))
    else $error("both outputs forced");
  a_oe_pass: assert property (armQ |-> serialPinOe == $past(gpioDirOe))
    else $error("pin direction altered");
  a_hispd_sel: assert property (armQ |-> highSpeedBaudSel == $past(msb))
    else $error("fast baud select wrong");
  a_ack_once: assert property (take |=> wbAckO ##1 !wbAckO)
    else $error("ack not one pulse");
endmodule
bind rad_top rad_top_checker #(.PORTS(PORTS)) uChk (.mclk, .resetn, .wbCycI, .wbStbI, .wbWeI,
  .wbAdrI, .wbDatI, .wbSelI, .wbAckO, .uartIn, .gpioDirOe, .requestToSendOutN,
  .terminalReadyOutN, .highSpeedBaudSel, .serialPinOe);

// ---- bench/rad_top_bench.sv ----
// Self-checking bench for the direction control block
`timescale 1ns/10ps
module rad_top_bench
  import rad_pkg::*;
();
  logic mclk = 0, resetn = 0, wbCycI = 0, wbStbI = 0, wbWeI = 0, run = 0;
  logic [7:0] wbAdrI = '0;
  logic [31:0] wbDatI = '0, wbDatO;
  logic [3:0] wbSelI = '0;
  logic wbAckO, busLine;
  rad_uart_s [5:0] uartIn = '0;
  rad_cfg_s [5:0] cfgM = '0;
  logic [5:0] gpioDirOe = '0, rts, dtr, hs, oe;
  logic [23:0] expQ[$];
  logic [31:0] rdQ[$];
  logic [63:0] rnd = '0;
  logic [23:0] pv;
  logic [7:0] ofs[4] = '{OFS_OPT12, OFS_OPT34, OFS_OPT5, OFS_OPT6};
  int numErrors = 0, cmpCount = 0;
  integer seed = 32'h31526c79;
  always #5 mclk = ~mclk;
  rad_top #(.PORTS(6)) DUT (.mclk, .resetn, .wbCycI, .wbStbI, .wbWeI, .wbAdrI, .wbDatI,
    .wbSelI, .wbDatO, .wbAckO, .uartIn, .gpioDirOe, .requestToSendOutN(rts),
    .terminalReadyOutN(dtr), .highSpeedBaudSel(hs), .serialPinOe(oe));
  rad_line_xcvr uLine (.driveEn(rts[0]), .txd(rnd[0]), .busLine);
  task automatic giveVerdict();
    $display("errors %0d compares %0d", numErrors, cmpCount);
    if (numErrors == 0 && cmpCount > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // One classic cycle; master waits for ack under a bound
  task automatic bus(input logic we, input logic [7:0] a, input logic [31:0] d,
                     input logic [3:0] s);
    int n = 0;
    @(posedge mclk);
    {wbCycI, wbStbI, wbWeI, wbAdrI, wbDatI, wbSelI} <= {2'b11, we, a, d, s};
    do begin
      @(posedge mclk);
      n++;
    end while (!wbAckO && n < 20);
    if (n >= 20) begin
      numErrors++;
      giveVerdict();
    end else begin
      {wbCycI, wbStbI} <= 2'b00;
    end
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    rdQ.push_back(e);
    bus(1'b0, a, 32'h0, 4'hf);
  endtask
  task automatic cmpPins(input logic [23:0] e);
    cmpCount++;
    if ({rts, dtr, hs, oe} !== e) begin
      numErrors++;
      $display("mismatch %0t pins %h exp %h", $time, {rts, dtr, hs, oe}, e);
    end
  endtask
  task automatic cmpRead(input logic [31:0] e);
    cmpCount++;
    if (wbDatO !== e) begin
      numErrors++;
      $display("mismatch %0t read %h exp %h", $time, wbDatO, e);
    end
  endtask
  function automatic logic [23:0] expPins();
    logic [5:0] r, d, h;
    logic a, l;
    for (int p = 0; p < 6; p++) begin
      a = cfgM[p].en & uartIn[p].fifoEnabled;
      l = (uartIn[p].txFifoEmpty & uartIn[p].txShiftEmpty) ? cfgM[p].pol : ~cfgM[p].pol;
      r[p] = (a & cfgM[p].sel) ? l : uartIn[p].mcrRtsN;
      d[p] = (a & ~cfgM[p].sel) ? l : uartIn[p].mcrDtrN;
      h[p] = uartIn[p].divisorMsb;
    end
    return {r, d, h, gpioDirOe};
  endfunction
  // Status word: empty, active and fast-baud bytes
  function automatic logic [31:0] expStatus();
    logic [5:0] e, a, h;
    for (int p = 0; p < 6; p++) begin
      e[p] = uartIn[p].txFifoEmpty & uartIn[p].txShiftEmpty;
      a[p] = cfgM[p].en & uartIn[p].fifoEnabled;
      h[p] = uartIn[p].divisorMsb;
    end
    return {10'h000, h, 2'b00, a, 2'b00, e};
  endfunction
  // Random port traffic; option model follows each acked write
  always @(posedge mclk) if (run) begin
    rnd = {$random(seed), $random(seed)};
    uartIn <= rnd[35:0];
    gpioDirOe <= rnd[41:36];
    #1;
    if (wbAckO && wbWeI && wbSelI[0]) begin
      case (wbAdrI)
        OFS_OPT12: cfgM[1:0] = {wbDatI[6:4], wbDatI[2:0]};
        OFS_OPT34: cfgM[3:2] = {wbDatI[6:4], wbDatI[2:0]};
        OFS_OPT5: cfgM[4] = wbDatI[2:0];
        OFS_OPT6: cfgM[5] = wbDatI[2:0];
        default: ;
      endcase
    end
    expQ.push_back(expPins());
  end
  // Pins lag inputs by one edge, so one note stays in flight
  always @(negedge mclk) begin
    if (expQ.size() > 1) cmpPins(expQ.pop_front());
    if (wbAckO && !wbWeI && rdQ.size() > 0) cmpRead(rdQ.pop_front());
  end
  initial begin
    repeat (3) @(posedge mclk);
    resetn <= 1'b1;
    run <= 1'b1;
    rd(OFS_OPT12, 32'h0);
    bus(1'b1, OFS_OPT12, 32'hff, 4'hf);
    rd(OFS_OPT12, 32'h77);
    bus(1'b1, OFS_OPT5, 32'hff, 4'hf);
    rd(OFS_OPT5, 32'h07);
    bus(1'b1, OFS_OPT34, 32'hff, 4'he);
    rd(OFS_OPT34, 32'h0);
    rd(8'h18, 32'h0);
    repeat (60) begin
      bus(1'b1, ofs[$random(seed) & 3], $random(seed), 4'hf);
      repeat (15) @(posedge mclk);
    end
    run <= 1'b0;
    repeat (3) @(posedge mclk);
    pv = expPins();
    rd(OFS_STATUS, expStatus());
    rd(OFS_PINS, {16'h0000, 2'b00, pv[17:12], 2'b00, pv[23:18]});
    if (rdQ.size() != 0) numErrors++;
    giveVerdict();
  end
  initial begin
    #100us;
    numErrors++;
    giveVerdict();
  end
endmodule
